// ==== core/lpw_cfg.svh ====
`ifndef LPW_CFG_SVH
`define LPW_CFG_SVH

// event lines
`define LPW_NUM_LINES       28
`define LPW_NUM_GPIO_LINES  16
`define LPW_NUM_FIXED_LINES 12
`define LPW_NUM_GPIO        51
`define LPW_GPIO_SEL_W      6
// fixed line positions
`define LPW_LINE_SUPPLY     16
`define LPW_LINE_RTC_ALARM  17
`define LPW_LINE_RTC_TAMPER 18
`define LPW_LINE_RTC_WAKE   19
`define LPW_LINE_SERIAL0    20
`define LPW_LINE_SERIAL1    21
`define LPW_LINE_I2C        22
`define LPW_LINE_LP_SERIAL  23
`define LPW_LINE_LP_TIMER   24
`define LPW_LINE_CMP0       25
`define LPW_LINE_CMP1       26
`define LPW_LINE_RTC_STAMP  27
// core clock ceilings per range, kHz
`define LPW_FMAX_R1_KHZ     32000
`define LPW_FMAX_R2_KHZ     16000
`define LPW_FMAX_R3_KHZ     4200
`define LPW_FMAX_LPRUN_KHZ  131
`define LPW_FREQ_W          16
// stop wake time
`define LPW_CLK_MHZ         25
`define LPW_STOP_WAKE_NS    3500
`define LPW_STOP_WAKE_CYC   ((`LPW_STOP_WAKE_NS * `LPW_CLK_MHZ) / 1000)
// pin edge to wake seen: capture, two sync stages, edge stage
`define LPW_WAKE_SYNC_CYC   4
`define LPW_WAKE_CNT_W      8

`endif

// ==== core/lpw_clock_limit.sv ====
`timescale 1ns/1ps
`include "lpw_cfg.svh"

// highest allowed core clock for the present range and mode
module lpw_clock_limit (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // selection
    input  wire logic [1:0]               range_sel,
    input  wire logic                     lp_reg,
    // ceiling in kHz
    output logic      [`LPW_FREQ_W-1:0]   fmax_khz
);
    typedef struct packed {
        logic [`LPW_FREQ_W-1:0] fmax;
    } lpw_lim_s;

    lpw_lim_s st;
    lpw_lim_s next_st;

    always_comb begin
        next_st = st;
        if (lp_reg) begin
            next_st.fmax = `LPW_FREQ_W'(`LPW_FMAX_LPRUN_KHZ);
        end else begin
            unique case (range_sel)
                lpw_pkg::LPW_RANGE1: next_st.fmax = `LPW_FREQ_W'(`LPW_FMAX_R1_KHZ);
                lpw_pkg::LPW_RANGE2: next_st.fmax = `LPW_FREQ_W'(`LPW_FMAX_R2_KHZ);
                default:             next_st.fmax = `LPW_FREQ_W'(`LPW_FMAX_R3_KHZ);
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fmax_khz = st.fmax;
endmodule

// ==== core/lpw_edge_line.sv ====
`timescale 1ns/1ps
`include "lpw_cfg.svh"

// one event line: async capture, sync, edge select
module lpw_edge_line (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // source and config
    input  wire logic line_in,
    input  wire logic rise_en,
    input  wire logic fall_en,
    // clear of the capture
    input  wire logic ack,
    // detected edge, one-cycle pulse
    output logic      hit
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic hit;
    } lpw_edge_s;

    lpw_edge_s st;
    lpw_edge_s next_st;
    logic      cap_rise;
    logic      cap_fall;
    logic      clr_rise;
    logic      clr_fall;

    // short pulses caught on the pin edge itself
    always_ff @(posedge line_in or posedge clr_rise) begin
        if (clr_rise) begin
            cap_rise <= 1'b0;
        end else begin
            cap_rise <= 1'b1;
        end
    end

    always_ff @(negedge line_in or posedge clr_fall) begin
        if (clr_fall) begin
            cap_fall <= 1'b0;
        end else begin
            cap_fall <= 1'b1;
        end
    end

    always_comb begin
        next_st      = st;
        next_st.s1   = (cap_rise & rise_en) | (cap_fall & fall_en);
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
        next_st.hit  = st.s2 & ~st.prev;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign clr_rise = sys_rst | ack | ~rise_en;
    assign clr_fall = sys_rst | ack | ~fall_en;
    assign hit      = st.hit;
endmodule

// ==== core/lpw_pkg.sv ====
package lpw_pkg;

    typedef enum logic [2:0] {
        LPW_RUN       = 3'b000,
        LPW_SLEEP     = 3'b001,
        LPW_LP_RUN    = 3'b010,
        LPW_LP_SLEEP  = 3'b011,
        LPW_STOP      = 3'b100,
        LPW_STOP_WAKE = 3'b101
    } lpw_mode_e;

    typedef enum logic [1:0] {
        LPW_SEL_SLEEP = 2'b00,
        LPW_SEL_LP    = 2'b01,
        LPW_SEL_STOP  = 2'b10
    } lpw_sel_e;

    typedef enum logic [1:0] {
        LPW_RANGE1 = 2'b01,
        LPW_RANGE2 = 2'b10,
        LPW_RANGE3 = 2'b11
    } lpw_range_e;

endpackage

// ==== core/lpw_power_ctrl.sv ====
`timescale 1ns/1ps
`include "lpw_cfg.svh"

// Behaviour
// - core clock ceiling follows regulator range
// - sleep stops only the processor clock
// - any interrupt or event wakes sleep
// - low-power run: slow multispeed rc, lp regulator
// - low-power sleep is sleep plus lp regulator
// - wake from lp sleep restores regulator on
// - stop gates core clocks and fast oscillators
// - stop keeps slow oscillators, regulator low-power
// - wake peripheral may request fast rc in stop
// - event line wakes stop within 3.5 us
// - 28 edge lines, interrupt or event each
// - per-line edge selection and independent masks
// - pending bit per unmasked interrupt
// - pulses shorter than clock are captured
// - 16 gpio-selectable lines, 12 fixed sources
// - comparator wake only with reference on
module lpw_power_ctrl #(
    parameter int NUM_LINES  = `LPW_NUM_LINES,
    parameter int GPIO_LINES = `LPW_NUM_GPIO_LINES,
    parameter int NUM_GPIO   = `LPW_NUM_GPIO
) (
    // clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   sys_rst,
    // core
    input  wire logic                                   wait_irq,
    input  wire logic                                   wait_evt,
    input  wire logic                                   deep_sel,
    input  wire logic                                   lp_reg_sel,
    input  wire logic                                   lp_run_req,
    input  wire logic [1:0]                             range_sel,
    // line configuration
    input  wire logic [NUM_LINES-1:0]                   rise_en,
    input  wire logic [NUM_LINES-1:0]                   fall_en,
    input  wire logic [NUM_LINES-1:0]                   irq_mask,
    input  wire logic [NUM_LINES-1:0]                   evt_mask,
    input  wire logic [NUM_LINES-1:0]                   pend_clr,
    input  wire logic [GPIO_LINES*`LPW_GPIO_SEL_W-1:0] gpio_sel,
    // event sources
    input  wire logic [NUM_GPIO-1:0]                    gpio_in,
    input  wire logic [`LPW_NUM_FIXED_LINES-1:0]        fixed_in,
    input  wire logic                                   vref_on,
    input  wire logic                                   periph_irq,
    input  wire logic                                   hsi_req,
    // status and control out
    output logic      [NUM_LINES-1:0]                   pending,
    output logic                                        line_irq,
    output logic                                        line_evt,
    output logic      [2:0]                             mode,
    output logic                                        cpu_clk_en,
    output logic                                        core_clk_en,
    output logic                                        reg_lp,
    output logic                                        pll_en,
    output logic                                        msi_en,
    output logic                                        msi_low,
    output logic                                        hse_en,
    output logic                                        hsi_en,
    output logic                                        ls_osc_en,
    output logic      [`LPW_FREQ_W-1:0]                 fmax_khz
);
    // line capture and sync stages already eat part of the wake budget
    localparam logic [`LPW_WAKE_CNT_W-1:0] WAKE_CYC =
        `LPW_WAKE_CNT_W'(`LPW_STOP_WAKE_CYC - `LPW_WAKE_SYNC_CYC);

    typedef struct packed {
        lpw_pkg::lpw_mode_e         mode;
        logic [NUM_LINES-1:0]       pend;
        logic [NUM_LINES-1:0]       ack;
        logic                       irq;
        logic                       evt;
        logic [`LPW_WAKE_CNT_W-1:0] wcnt;
        logic                       cpu_en;
        logic                       core_en;
        logic                       reg_lp;
        logic                       fast_en;
        logic                       msi_low;
        logic                       hsi_en;
        logic                       ls_en;
    } lpw_st_s;

    lpw_st_s              st;
    lpw_st_s              next_st;
    logic [NUM_LINES-1:0] src;
    logic [NUM_LINES-1:0] hit;
    logic [NUM_LINES-1:0] new_irq;
    logic [NUM_LINES-1:0] new_evt;
    logic                 any_wake;
    logic                 enter_wait;

    // line sources: 16 gpio muxed, 12 fixed
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            if (gi < GPIO_LINES) begin : g_gpio
                logic [`LPW_GPIO_SEL_W-1:0] sel;
                assign sel = gpio_sel[gi*`LPW_GPIO_SEL_W +: `LPW_GPIO_SEL_W];
                assign src[gi] = (int'(sel) < NUM_GPIO) ? gpio_in[sel] : 1'b0;
            end else if (gi == `LPW_LINE_CMP0 || gi == `LPW_LINE_CMP1) begin : g_cmp
                assign src[gi] = fixed_in[gi-GPIO_LINES] & vref_on;
            end else begin : g_fix
                assign src[gi] = fixed_in[gi-GPIO_LINES];
            end
            lpw_edge_line u_edge (
                .clock   (clock),
                .sys_rst (sys_rst),
                .line_in (src[gi]),
                .rise_en (rise_en[gi]),
                .fall_en (fall_en[gi]),
                .ack     (st.ack[gi]),
                .hit     (hit[gi])
            );
        end
    endgenerate

    lpw_clock_limit u_limit (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .range_sel (range_sel),
        .lp_reg    (st.msi_low),
        .fmax_khz  (fmax_khz)
    );

    assign new_irq    = hit & irq_mask;
    assign new_evt    = hit & evt_mask;
    assign any_wake   = (|new_irq) | (|new_evt) | (|st.pend);
    assign enter_wait = wait_irq | wait_evt;

    always_comb begin
        next_st     = st;
        next_st.ack = hit; // edge capture released once seen
        // set wins over a write-one clear
        next_st.pend = (st.pend & ~pend_clr) | new_irq;
        next_st.irq  = |next_st.pend;
        next_st.evt  = |new_evt;
        unique case (st.mode)
            lpw_pkg::LPW_RUN, lpw_pkg::LPW_LP_RUN: begin
                if (enter_wait) begin
                    if (deep_sel) begin
                        next_st.mode = lpw_pkg::LPW_STOP;
                    end else if (lp_reg_sel) begin
                        next_st.mode = lpw_pkg::LPW_LP_SLEEP;
                    end else begin
                        next_st.mode = lpw_pkg::LPW_SLEEP;
                    end
                end else if (lp_run_req) begin
                    next_st.mode = lpw_pkg::LPW_LP_RUN;
                end else begin
                    next_st.mode = lpw_pkg::LPW_RUN;
                end
            end
            lpw_pkg::LPW_SLEEP: begin
                if (any_wake | periph_irq) begin
                    next_st.mode = lpw_pkg::LPW_RUN;
                end
            end
            lpw_pkg::LPW_LP_SLEEP: begin
                if (any_wake | periph_irq) begin
                    next_st.mode = lpw_pkg::LPW_RUN;
                end
            end
            lpw_pkg::LPW_STOP: begin
                if (any_wake) begin
                    next_st.mode = lpw_pkg::LPW_STOP_WAKE;
                    next_st.wcnt = WAKE_CYC;
                end
            end
            lpw_pkg::LPW_STOP_WAKE: begin
                if (st.wcnt <= `LPW_WAKE_CNT_W'(1)) begin
                    next_st.mode = lpw_pkg::LPW_RUN;
                    next_st.wcnt = '0;
                end else begin
                    next_st.wcnt = st.wcnt - `LPW_WAKE_CNT_W'(1);
                end
            end
            default: begin
                next_st.mode = lpw_pkg::LPW_RUN;
            end
        endcase
        // outputs follow the next mode
        next_st.cpu_en  = next_st.mode == lpw_pkg::LPW_RUN ||
                          next_st.mode == lpw_pkg::LPW_LP_RUN;
        next_st.core_en = next_st.mode != lpw_pkg::LPW_STOP;
        next_st.reg_lp  = next_st.mode == lpw_pkg::LPW_LP_RUN ||
                          next_st.mode == lpw_pkg::LPW_LP_SLEEP ||
                          next_st.mode == lpw_pkg::LPW_STOP;
        next_st.fast_en = next_st.mode != lpw_pkg::LPW_STOP;
        next_st.msi_low = next_st.mode == lpw_pkg::LPW_LP_RUN;
        next_st.hsi_en  = next_st.fast_en | hsi_req;
        next_st.ls_en   = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st         <= '0;
            st.cpu_en  <= 1'b1;
            st.core_en <= 1'b1;
            st.fast_en <= 1'b1;
            st.hsi_en  <= 1'b1;
            st.ls_en   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign pending     = st.pend;
    assign line_irq    = st.irq;
    assign line_evt    = st.evt;
    assign mode        = st.mode;
    assign cpu_clk_en  = st.cpu_en;
    assign core_clk_en = st.core_en;
    assign reg_lp      = st.reg_lp;
    assign pll_en      = st.fast_en;
    assign msi_en      = st.fast_en;
    assign msi_low     = st.msi_low;
    assign hse_en      = st.fast_en;
    assign hsi_en      = st.hsi_en;
    assign ls_osc_en   = st.ls_en;

    // assertions
    sequence s_stop_wake;
        st.mode == lpw_pkg::LPW_STOP && any_wake;
    endsequence

    a_stop_wake_time: assert property (
        @(posedge clock) disable iff (sys_rst)
        s_stop_wake |-> ##[1:84] (mode == lpw_pkg::LPW_RUN))
        else $error("stop wake too slow");

    a_stop_gates: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == lpw_pkg::LPW_STOP |-> !core_clk_en && !pll_en && !hse_en)
        else $error("clocks running in stop");

    a_stop_lp_reg: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == lpw_pkg::LPW_STOP |-> reg_lp && ls_osc_en)
        else $error("stop regulator not low power");

    a_sleep_cpu_off: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == lpw_pkg::LPW_SLEEP |-> !cpu_clk_en && core_clk_en)
        else $error("sleep clocking wrong");

    a_sleep_wake: assert property (
        @(posedge clock) disable iff (sys_rst)
        st.mode == lpw_pkg::LPW_SLEEP && periph_irq |=>
        mode == lpw_pkg::LPW_RUN && cpu_clk_en)
        else $error("sleep did not wake");

    a_lps_wake_reg: assert property (
        @(posedge clock) disable iff (sys_rst)
        st.mode == lpw_pkg::LPW_LP_SLEEP && periph_irq |=> !reg_lp)
        else $error("regulator stayed low power");

    a_pend_set: assert property (
        @(posedge clock) disable iff (sys_rst)
        new_irq[0] |=> pending[0])
        else $error("pending not set");

    a_pend_clear: assert property (
        @(posedge clock) disable iff (sys_rst)
        pending[0] && pend_clr[0] && !new_irq[0] |=> !pending[0])
        else $error("pending not cleared");

    a_wait_enter: assert property (
        @(posedge clock) disable iff (sys_rst)
        st.mode == lpw_pkg::LPW_RUN && wait_irq && deep_sel |=>
        mode == lpw_pkg::LPW_STOP)
        else $error("wait did not enter stop");

    sequence s_wait_light;
        st.mode == lpw_pkg::LPW_RUN && enter_wait && !deep_sel;
    endsequence

    a_wait_sleep: assert property (
        @(posedge clock) disable iff (sys_rst)
        s_wait_light ##0 !lp_reg_sel |=> mode == lpw_pkg::LPW_SLEEP)
        else $error("wait did not enter sleep");

    a_wait_lp_sleep: assert property (
        @(posedge clock) disable iff (sys_rst)
        s_wait_light ##0 lp_reg_sel |=> mode == lpw_pkg::LPW_LP_SLEEP)
        else $error("wait did not enter low-power sleep");

    a_lp_run_clk: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == lpw_pkg::LPW_LP_RUN |-> msi_low && reg_lp && cpu_clk_en)
        else $error("low-power run clocking wrong");

    a_lps_state: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == lpw_pkg::LPW_LP_SLEEP |-> reg_lp && !cpu_clk_en)
        else $error("low-power sleep state wrong");

    a_stop_hsi_req: assert property (
        @(posedge clock) disable iff (sys_rst)
        st.mode == lpw_pkg::LPW_STOP && hsi_req |=> hsi_en)
        else $error("fast rc request ignored");

    a_wake_run_clk: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == lpw_pkg::LPW_STOP_WAKE |-> core_clk_en && !cpu_clk_en)
        else $error("stop wake clocking wrong");

    a_evt_pulse: assert property (
        @(posedge clock) disable iff (sys_rst)
        (|new_evt) |=> line_evt)
        else $error("event request lost");

    a_irq_follows: assert property (
        @(posedge clock) disable iff (sys_rst)
        line_irq == (|pending))
        else $error("interrupt request not pending");

    a_mask_quiet: assert property (
        @(posedge clock) disable iff (sys_rst)
        !irq_mask[0] && !pending[0] |=> !pending[0])
        else $error("masked line set pending");

    a_cmp_gate: assert property (
        @(posedge clock) disable iff (sys_rst)
        !vref_on |-> !src[`LPW_LINE_CMP0] && !src[`LPW_LINE_CMP1])
        else $error("comparator line without reference");

    a_hit_single: assert property (
        @(posedge clock) disable iff (sys_rst)
        hit[0] |=> !hit[0])
        else $error("edge reported twice");

    a_fmax_lp_run: assert property (
        @(posedge clock) disable iff (sys_rst)
        st.msi_low |=> fmax_khz == `LPW_FREQ_W'(`LPW_FMAX_LPRUN_KHZ))
        else $error("low-power run ceiling wrong");

    a_fmax_range2: assert property (
        @(posedge clock) disable iff (sys_rst)
        !st.msi_low && range_sel == lpw_pkg::LPW_RANGE2 |=>
        fmax_khz == `LPW_FREQ_W'(`LPW_FMAX_R2_KHZ))
        else $error("range ceiling wrong");
endmodule

// ==== dv/lpw_src_model.sv ====
`timescale 1ns/1ps
`include "lpw_cfg.svh"

// pins and fixed event sources, async to the clock
module lpw_src_model (
    // event sources
    output logic [`LPW_NUM_GPIO-1:0]        gpio_in,
    output logic [`LPW_NUM_FIXED_LINES-1:0] fixed_in
);
    initial begin
        gpio_in  = '0;
        fixed_in = '0;
    end

    // levels land 13 ns after the call, away from the clock edge
    task automatic set_lvl(input logic [`LPW_NUM_GPIO-1:0] g,
                           input logic [`LPW_NUM_FIXED_LINES-1:0] f);
        #13;
        gpio_in  = g;
        fixed_in = f;
    endtask

    // glitch narrower than one clock period
    task automatic pulse(input int pin);
        #13;
        gpio_in[pin] = 1'b1;
        #15;
        gpio_in[pin] = 1'b0;
    endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "lpw_cfg.svh"

module testbench;
    localparam int NL = `LPW_NUM_LINES;
    localparam int GW = `LPW_NUM_GPIO_LINES * `LPW_GPIO_SEL_W;
    logic                     clock      = 1'b0;
    logic                     sys_rst    = 1'b1;
    logic                     wait_irq   = 1'b0;
    logic                     wait_evt   = 1'b0;
    logic                     deep_sel   = 1'b0;
    logic                     lp_reg_sel = 1'b0;
    logic                     lp_run_req = 1'b0;
    logic [1:0]               range_sel  = 2'h1;
    logic [NL-1:0]            rise_en    = '0;
    logic [NL-1:0]            fall_en    = '0;
    logic [NL-1:0]            irq_mask   = '0;
    logic [NL-1:0]            evt_mask   = '0;
    logic [NL-1:0]            pend_clr   = '0;
    logic [GW-1:0]            gpio_sel   = '0;
    logic                     vref_on    = 1'b0;
    logic                     periph_irq = 1'b0;
    logic                     hsi_req    = 1'b0;
    logic [`LPW_NUM_GPIO-1:0] gpio_in;
    logic [11:0]              fixed_in;
    logic [NL-1:0]            pending;
    logic [2:0]               mode;
    logic [`LPW_FREQ_W-1:0]   fmax_khz;
    logic                     line_irq;
    logic                     line_evt;
    logic                     cpu_clk_en;
    logic                     core_clk_en;
    logic                     reg_lp;
    logic                     pll_en;
    logic                     msi_en;
    logic                     msi_low;
    logic                     hse_en;
    logic                     hsi_en;
    logic                     ls_osc_en;
    // bench model state
    logic [NL-1:0]            lv = '0;
    logic [NL-1:0]            xp;
    logic [NL-1:0]            hit;
    logic [NL-1:0]            re;
    logic [NL-1:0]            fe;
    logic [NL-1:0]            im;
    logic [NL-1:0]            em;
    logic [NL-1:0]            nl;
    logic [NL-1:0]            clr;
    logic [NL-1:0]            a;
    logic [NL-1:0]            b;
    logic [NL-1:0]            c;
    logic                     vr;
    logic [31:0]              rng = 32'h0000_e4e5;
    int                       err_total = 0;
    int                       comparisons = 0;
    int                       evt_n = 0;
    int                       n;

    lpw_power_ctrl lpw_power_ctrl_i (
        .clock, .sys_rst, .wait_irq, .wait_evt, .deep_sel, .lp_reg_sel,
        .lp_run_req, .range_sel, .rise_en, .fall_en, .irq_mask, .evt_mask,
        .pend_clr, .gpio_sel, .gpio_in, .fixed_in, .vref_on, .periph_irq,
        .hsi_req, .pending, .line_irq, .line_evt, .mode, .cpu_clk_en,
        .core_clk_en, .reg_lp, .pll_en, .msi_en, .msi_low, .hse_en,
        .hsi_en, .ls_osc_en, .fmax_khz
    );

    lpw_src_model lpw_src_model_i (
        .gpio_in  (gpio_in),
        .fixed_in (fixed_in)
    );

    always #20 clock = ~clock;

    always @(posedge clock) begin
        if (line_evt === 1'b1)
            evt_n++;
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic [NL-1:0] rnd_l();
        logic [31:0] v;
        v = rnd();
        return v[NL-1:0];
    endfunction

    function automatic int fx(input logic [1:0] r);
        if (r == 2'h1)
            return `LPW_FMAX_R1_KHZ;
        if (r == 2'h2)
            return `LPW_FMAX_R2_KHZ;
        return `LPW_FMAX_R3_KHZ;
    endfunction

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic wait_mode(input logic [2:0] m, output int k);
        k = 0;
        while (mode !== m && k < 200) begin
            cyc(1);
            k++;
        end
        chk("mode", mode, m);
    endtask

    task automatic sleep_in(input logic d, input logic l, input logic e);
        @(posedge clock);
        deep_sel   <= d;
        lp_reg_sel <= l;
        wait_irq   <= !e;
        wait_evt   <= e;
        @(posedge clock);
        wait_irq   <= 1'b0;
        wait_evt   <= 1'b0;
    endtask

    task automatic drive(input logic [NL-1:0] v);
        logic [`LPW_NUM_GPIO-1:0] g;
        g = '0;
        for (int l = 0; l < 16; l++)
            g[3*l+1] = v[l];
        lpw_src_model_i.set_lvl(g, v[NL-1:16]);
        lv = v;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(40 * 5000);
        err_total++;
        test_done();
    end

    initial begin
        for (int l = 0; l < 16; l++)
            gpio_sel[l*6 +: 6] <= 6'(3*l+1);
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        cyc(2);
        chk("mode", mode, 0);
        chk("pending", pending, 0);
        chk("ls_osc_en", ls_osc_en, 1);
        for (int r = 0; r < 4; r++) begin
            @(posedge clock);
            range_sel <= 2'(r);
            cyc(3);
            chk("fmax", fmax_khz, fx(2'(r)));
        end
        $display("test ranges done");
        for (int v = 0; v < 2; v++) begin
            sleep_in(1'b0, v[0], v[0]);
            wait_mode(v ? lpw_pkg::LPW_LP_SLEEP : lpw_pkg::LPW_SLEEP, n);
            chk("cpu_clk_en", cpu_clk_en, 0);
            chk("core_clk_en", core_clk_en, 1);
            chk("reg_lp", reg_lp, v);
            @(posedge clock);
            periph_irq <= 1'b1;
            @(posedge clock);
            periph_irq <= 1'b0;
            wait_mode(lpw_pkg::LPW_RUN, n);
            chk("reg_lp", reg_lp, 0);
            chk("cpu_clk_en", cpu_clk_en, 1);
        end
        @(posedge clock);
        lp_reg_sel <= 1'b0;
        lp_run_req <= 1'b1;
        wait_mode(lpw_pkg::LPW_LP_RUN, n);
        chk("msi_low", {msi_low, msi_en, reg_lp}, 7);
        cyc(1);
        chk("fmax", fmax_khz, `LPW_FMAX_LPRUN_KHZ);
        @(posedge clock);
        lp_run_req <= 1'b0;
        wait_mode(lpw_pkg::LPW_RUN, n);
        $display("test modes done");
        for (int t = 0; t < 12; t++) begin
            re = rnd_l();
            fe = rnd_l();
            im = rnd_l();
            em = rnd_l();
            nl = rnd_l();
            vr = rng[3];
            a = lv;
            b = lv;
            c = nl;
            if (!vref_on)
                a[`LPW_LINE_CMP1:`LPW_LINE_CMP0] = 2'h0;
            if (!vr) begin
                b[`LPW_LINE_CMP1:`LPW_LINE_CMP0] = 2'h0;
                c[`LPW_LINE_CMP1:`LPW_LINE_CMP0] = 2'h0;
            end
            hit = (re & ((~a & b) | (~b & c))) |
                  (fe & ((a & ~b) | (b & ~c)));
            xp = hit & im;
            @(posedge clock);
            rise_en  <= re;
            fall_en  <= fe;
            irq_mask <= im;
            evt_mask <= em;
            evt_n = 0;
            @(posedge clock);
            vref_on  <= vr;
            drive(nl);
            cyc(8);
            chk("pending", pending, xp);
            chk("line_irq", line_irq, |xp);
            chk("line_evt", evt_n != 0, |(hit & em));
            clr = rnd_l();
            @(posedge clock);
            pend_clr <= clr;
            cyc(1);
            chk("pend_clr", pending, xp & ~clr);
            @(posedge clock);
            pend_clr <= '1;
            @(posedge clock);
            pend_clr <= '0;
        end
        $display("test lines done");
        @(posedge clock);
        rise_en <= '0;
        fall_en <= '0;
        drive('0);
        cyc(8);
        @(posedge clock);
        rise_en  <= 28'h1;
        irq_mask <= 28'h1;
        sleep_in(1'b1, 1'b0, 1'b0);
        wait_mode(lpw_pkg::LPW_STOP, n);
        chk("core_clk_en", {core_clk_en, cpu_clk_en}, 0);
        chk("osc_en", {pll_en, msi_en, hse_en, hsi_en}, 0);
        chk("slow_keep", {ls_osc_en, reg_lp}, 3);
        @(posedge clock);
        hsi_req <= 1'b1;
        cyc(3);
        chk("hsi_en", hsi_en, 1);
        @(posedge clock);
        hsi_req <= 1'b0;
        cyc(2);
        chk("hsi_en", hsi_en, 0);
        lpw_src_model_i.pulse(1);
        wait_mode(lpw_pkg::LPW_RUN, n);
        chk("wake_time", n * 40 <= `LPW_STOP_WAKE_NS, 1);
        chk("pending", pending, 28'h1);
        chk("core_clk_en", core_clk_en, 1);
        $display("test stop done");
        test_done();
    end
endmodule
